// >>> verification/rtcdst_control_tb_top.sv
// Self-checking bench for the compensation and saving-time control block, with a reference model.
// Assumes the design package, constants header and control module are compiled before it.
`timescale 1ns/1ps
module rtcdst_control_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic [4:0] fScale = 5'h00;
	logic [7:0] fInt = 8'h00;
	logic [7:0] fCurve = 8'h00;
	logic mainSupplyOk = 1'b1;
	logic secondTick = 1'b0;
	logic [7:0] curMonth = 8'h01;
	logic [7:0] curDate = 8'h01;
	logic [2:0] curWeekday = 3'h0;
	logic [7:0] curHour = 8'h00;
	logic [7:0] curMinute = 8'h00;
	logic [7:0] curSecond = 8'h00;
	logic [4:0] daysInMonth = 5'h1e;
	logic convDone = 1'b0;
	logic [9:0] convTemp = 10'h000;
	logic [7:0] convAnalog = 8'h00;
	logic [7:0] convDigital = 8'h00;
	logic convStart;
	logic [7:0] aTrim;
	logic [7:0] dTrim;
	logic fwdP;
	logic revP;
	logic applied;
	logic [7:0] eA = 8'h00;
	logic [7:0] eD = 8'h00;
	logic [7:0] wv;
	int err_total = 0;
	int num_checks = 0;
	int starts, fwds, revs, i, k, n, app, lastT;
	int mreg [int];
	localparam logic [15:0] TBL [8] = '{16'h1584, 16'h1648, 16'h1700, 16'h1802,
		16'h1910, 16'h1a78, 16'h1b00, 16'h1c02};
	localparam logic [39:0] CASES [10] = '{40'h0405011e02, 40'h0405001e82, 40'h0405001e02,
		40'h1024001f02, 40'h1025001f02, 40'h1025001f02, 40'h0412001e02, 40'h0401001e02,
		40'h0415031e02, 40'h1024001e02};
	localparam int PER [4] = '{1802, 60, 600, 1800};

	rtcdst_control rtcdst_control_inst (.clk(clk), .reset(reset), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.factoryScale(fScale), .factoryIntercept(fInt), .factoryCurve(fCurve),
		.mainSupplyOk(mainSupplyOk), .secondTick(secondTick), .curMonth(curMonth),
		.curDate(curDate), .curWeekday(curWeekday), .curHour(curHour), .curMinute(curMinute),
		.curSecond(curSecond), .daysInMonth(daysInMonth), .convDone(convDone),
		.convTemp(convTemp), .convAnalog(convAnalog), .convDigital(convDigital),
		.convStart(convStart), .analogFreqTrim(aTrim), .digitalFreqTrim(dTrim),
		.saveForwardPulse(fwdP), .saveReversePulse(revP), .savingForwardApplied(applied));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk(regRdata, mreg.exists(a) ? 8'(mreg[a]) : 8'h00);
	endtask

	task automatic tick;
		@(posedge clk);
		secondTick <= 1'b1;
		@(posedge clk);
		secondTick <= 1'b0;
		repeat (3) begin
			#1;
			starts += convStart;
			fwds += fwdP;
			revs += revP;
			@(posedge clk);
		end
	endtask

	task automatic ticksToStart(input int lim, output int cnt);
		starts = 0;
		for (cnt = 1; cnt <= lim; cnt++) begin
			tick();
			if (starts > 0) begin
				break;
			end
		end
	endtask

	task automatic waitStart;
		int w;
		for (w = 0; w < 20 && convStart !== 1'b1; w++) begin
			@(posedge clk);
			#1;
		end
		if (w == 20) begin
			err_total++;
			report_and_stop();
		end
	endtask

	task automatic done(input logic [9:0] t);
		logic [7:0] a;
		logic [7:0] d;
		a = 8'($urandom);
		d = 8'($urandom);
		@(posedge clk);
		convDone <= 1'b1;
		convTemp <= t;
		convAnalog <= a;
		convDigital <= d;
		@(posedge clk);
		convDone <= 1'b0;
		if (lastT < 0 || int'(t) != lastT) begin
			eA = a;
			eD = d;
		end
		lastT = int'(t);
		repeat (2) @(posedge clk);
		#1;
		chk(aTrim, eA);
		chk(dTrim, eD);
	endtask

	task automatic wrScale(input logic [7:0] d);
		wr(8'h0d, d);
		mreg[13] = {24'h0, d[7:5], fScale};
	endtask

	function automatic bit hit(int mon, int wdr, int dat, int hr, logic [39:0] c);
		int d;
		int wk;
		d = c[31:28] * 10 + c[27:24];
		wk = (wdr >> 3) & 7;
		if ((mon & 8'h1f) != c[39:32] || (hr & 8'h3f) != (c[7:0] & 8'h3f)) begin
			return 0;
		end
		if (!wdr[6]) begin
			return (dat & 8'h3f) == c[31:24];
		end
		if (wdr[2:0] != c[18:16]) begin
			return 0;
		end
		return wk == 7 ? d + 7 > c[12:8] : (d - 1) / 7 + 1 == wk;
	endfunction

	task automatic runCase(input logic [39:0] c);
		bit f;
		bit r;
		fwds = 0;
		revs = 0;
		@(posedge clk);
		curMonth <= c[39:32];
		curDate <= c[31:24];
		curWeekday <= c[18:16];
		daysInMonth <= c[12:8];
		curHour <= c[7:0];
		tick();
		f = mreg[21][7] && app == 0 && hit(mreg[21], mreg[22], mreg[23], mreg[24], c);
		r = mreg[21][7] && app == 1 && hit(mreg[25], mreg[26], mreg[27], mreg[28], c);
		if (f) begin
			app = 1;
		end
		if (r) begin
			app = 0;
		end
		chk(16'(fwds), {15'h0, f});
		chk(16'(revs), {15'h0, r});
		chk({15'h0, applied}, 16'(app));
	endtask

	initial begin
		void'($urandom(32'hf6d53ffd));
		fScale <= 5'($urandom);
		fInt <= 8'($urandom);
		fCurve <= 8'($urandom);
		app = 0;
		lastT = -1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		mreg[11] = fInt;
		mreg[12] = fCurve;
		mreg[13] = fScale;
		for (i = 21; i <= 28; i++) begin
			mreg[i] = 0;
		end
		for (i = 11; i <= 29; i++) begin
			rdChk(8'(i));
		end
		wr(8'h0b, 8'($urandom));
		wr(8'h0c, 8'($urandom));
		wr(8'h30, 8'($urandom));
		rdChk(8'h0b);
		rdChk(8'h0c);
		rdChk(8'h30);
		wrScale({1'b0, 7'($urandom)});
		rdChk(8'h0d);
		for (k = 0; k < 3; k++) begin
			wrScale({1'b1, 7'($urandom)});
			waitStart();
			rdChk(8'h0d);
			done(k == 2 ? 10'h155 : 10'h0aa);
		end
		ticksToStart(70, n);
		done(10'($urandom));
		ticksToStart(70, n);
		chk(16'(n), 16'h003c);
		done(10'($urandom));
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			mainSupplyOk <= 1'b1;
			wv = {1'b1, 2'(k), 5'($urandom)};
			wrScale(wv);
			waitStart();
			done(10'($urandom));
			@(posedge clk);
			mainSupplyOk <= 1'b0;
			for (i = 0; i < 2; i++) begin
				ticksToStart(1801, n);
				if (starts > 0) begin
					done(10'($urandom));
				end
			end
			chk(16'(n), 16'(PER[k]));
		end
		@(posedge clk);
		mainSupplyOk <= 1'b1;
		wrScale({1'b0, 7'($urandom)});
		for (i = 0; i < 8; i++) begin
			wr(TBL[i][15:8], TBL[i][7:0]);
			mreg[TBL[i][15:8]] = TBL[i][7:0];
		end
		for (i = 0; i < 8; i++) begin
			rdChk(TBL[i][15:8]);
		end
		for (k = 0; k < 10; k++) begin
			if (k == 8) begin
				wr(8'h15, 8'h04);
				mreg[21] = 8'h04;
				app = 0;
				rdChk(8'h15);
				chk({15'h0, applied}, 16'h0000);
				wr(8'h16, 8'h00);
				wr(8'h17, 8'h15);
				wr(8'h15, 8'h84);
				mreg[22] = 8'h00;
				mreg[23] = 8'h15;
				mreg[21] = 8'h84;
			end
			runCase(CASES[k]);
		end
		report_and_stop();
	end
endmodule

// >>> verilog/rtcdst_comp_seq.sv
// Compensation sequencer: periodic and write-triggered temperature conversion, trim loading.
// Assumes secondTick, convDone and conversion results come from logic on the same clock.
`timescale 1ns/1ps
`include "rtcdst_regs.svh"
module rtcdst_comp_seq #(
	parameter logic [7:0] TRIM_RESET = 8'h00
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic secondTick,
	input wire logic tempSenseEnable,
	input wire logic [1:0] backupMode,
	input wire logic mainSupplyOk,
	input wire logic startReq,
	input wire logic convDone,
	input wire logic [9:0] convTemp,
	input wire logic [7:0] convAnalog,
	input wire logic [7:0] convDigital,
	output logic convStart,
	output logic [7:0] analogTrim,
	output logic [7:0] digitalTrim
);
	rtcdst_pkg::rtcdst_comp_t cur_reg, cur_next;
	logic [10:0] period;
	logic runNow;

	// Picks the correction period for the present supply and backup mode.
	always_comb begin
		period = `RTCDST_PERIOD_MAIN_S;
		runNow = tempSenseEnable;
		if (!mainSupplyOk) begin
			unique case (backupMode)
				2'h0: runNow = 1'b0;
				2'h1: period = `RTCDST_PERIOD_BK1_S;
				2'h2: period = `RTCDST_PERIOD_BK2_S;
				2'h3: period = `RTCDST_PERIOD_BK3_S;
			endcase
		end
	end

	always_comb begin
		cur_next = cur_reg;
		cur_next.convStart = 1'b0;
		if (!runNow) begin
			cur_next.secCount = 11'h000;
		end else if (secondTick) begin
			cur_next.secCount = (cur_reg.secCount + 11'h001 >= period) ? 11'h000 :
				cur_reg.secCount + 11'h001;
		end
		unique case (cur_reg.state)
			rtcdst_pkg::COMP_IDLE: begin
				if (startReq || (runNow && secondTick &&
					cur_reg.secCount + 11'h001 >= period)) begin
					cur_next.convStart = 1'b1;
					cur_next.state = rtcdst_pkg::COMP_WAIT;
				end
			end
			rtcdst_pkg::COMP_WAIT: begin
				if (convDone) begin
					cur_next.state = rtcdst_pkg::COMP_IDLE;
					if (!cur_reg.tempValid || convTemp != cur_reg.lastTemp) begin
						cur_next.analogTrim = convAnalog;
						cur_next.digitalTrim = convDigital;
					end
					cur_next.lastTemp = convTemp;
					cur_next.tempValid = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cur_reg <= '{state: rtcdst_pkg::COMP_IDLE, secCount: 11'h000, lastTemp: 10'h000,
				tempValid: 1'b0, convStart: 1'b0, analogTrim: TRIM_RESET,
				digitalTrim: TRIM_RESET};
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign convStart = cur_reg.convStart;
	assign analogTrim = cur_reg.analogTrim;
	assign digitalTrim = cur_reg.digitalTrim;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	write_start_a: assert property (
		startReq && cur_reg.state == rtcdst_pkg::COMP_IDLE |=> convStart)
		else $error("Write with sensing enabled did not start a conversion.");
	period_bound_a: assert property (
		runNow && mainSupplyOk |-> cur_reg.secCount < 11'h03c)
		else $error("Correction period counter ran past sixty seconds.");
	same_temp_a: assert property (
		cur_reg.state == rtcdst_pkg::COMP_WAIT && convDone && cur_reg.tempValid &&
		convTemp == cur_reg.lastTemp |=> $stable(analogTrim) && $stable(digitalTrim))
		else $error("Trim reloaded although temperature was unchanged.");
	cover_periodic_c: cover property (runNow && secondTick && cur_reg.secCount == 11'h03b);
endmodule

// >>> verilog/rtcdst_control.sv
// Compensation control and automatic saving-time registers of the real-time clock.
// Assumes a serial engine on clk drives regWrite/regRead and calendar inputs are on clk.
`timescale 1ns/1ps
`include "rtcdst_regs.svh"
module rtcdst_control #(
	parameter logic [7:0] TRIM_RESET = 8'h00
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic [4:0] factoryScale,
	input wire logic [7:0] factoryIntercept,
	input wire logic [7:0] factoryCurve,
	input wire logic mainSupplyOk,
	input wire logic secondTick,
	input wire logic [7:0] curMonth,
	input wire logic [7:0] curDate,
	input wire logic [2:0] curWeekday,
	input wire logic [7:0] curHour,
	input wire logic [7:0] curMinute,
	input wire logic [7:0] curSecond,
	input wire logic [4:0] daysInMonth,
	input wire logic convDone,
	input wire logic [9:0] convTemp,
	input wire logic [7:0] convAnalog,
	input wire logic [7:0] convDigital,
	output logic convStart,
	output logic [7:0] analogFreqTrim,
	output logic [7:0] digitalFreqTrim,
	output logic saveForwardPulse,
	output logic saveReversePulse,
	output logic savingForwardApplied
);
	rtcdst_pkg::rtcdst_ctl_t ctl_reg, ctl_next;
	logic [4:0] dateBin;
	logic atHourTop;
	logic fwdHit;
	logic revHit;

	// Converts a two-digit BCD value to binary.
	function automatic logic [4:0] bcdToBin(input logic [7:0] bcd);
		logic [7:0] tens;
		tens = {4'h0, bcd[7:4]};
		return 5'((tens << 3) + (tens << 1) + {4'h0, bcd[3:0]});
	endfunction

	// Decides whether the calendar stands on a programmed saving point.
	function automatic logic pointMatch(input logic [7:0] monthReg, input logic [7:0] weekReg,
		input logic [7:0] dateReg, input logic [7:0] hourReg, input logic [4:0] dBin,
		input logic [2:0] wday, input logic [4:0] dim, input logic [7:0] mon,
		input logic [7:0] dateNow, input logic [7:0] hourNow);
		logic dayOk;
		logic [2:0] weekNow;
		logic [5:0] datePlus;
		weekNow = 3'(((dBin - 5'h01) / 5'h07) + 5'h01);
		datePlus = {1'b0, dBin} + 6'h07;
		if (weekReg[`RTCDST_BIT_WEEK_SEL]) begin
			if (weekReg[5:3] == `RTCDST_WEEK_LAST) begin
				dayOk = (wday == weekReg[2:0]) && (datePlus > {1'b0, dim});
			end else begin
				dayOk = (wday == weekReg[2:0]) && (weekNow == weekReg[5:3]);
			end
		end else begin
			dayOk = (dateNow & `RTCDST_DATE_MASK) == (dateReg & `RTCDST_DATE_MASK);
		end
		return dayOk && ((mon & `RTCDST_MONTH_MASK) == (monthReg & `RTCDST_MONTH_MASK)) &&
			((hourNow & `RTCDST_HOUR_MASK) == (hourReg & `RTCDST_HOUR_MASK));
	endfunction

	always_comb begin
		dateBin = bcdToBin(curDate & `RTCDST_DATE_MASK);
		atHourTop = secondTick && curMinute == 8'h00 && curSecond == 8'h00;
		fwdHit = atHourTop && pointMatch(ctl_reg.fwdMonth, ctl_reg.fwdWeekDay, ctl_reg.fwdDate,
			ctl_reg.fwdHour, dateBin, curWeekday, daysInMonth, curMonth, curDate, curHour);
		revHit = atHourTop && pointMatch(ctl_reg.revMonth, ctl_reg.revWeekDay, ctl_reg.revDate,
			ctl_reg.revHour, dateBin, curWeekday, daysInMonth, curMonth, curDate, curHour);
	end

	always_comb begin
		ctl_next = ctl_reg;
		ctl_next.fwdPulse = 1'b0;
		ctl_next.revPulse = 1'b0;
		ctl_next.compStart = 1'b0;
		ctl_next.supplyMeta = mainSupplyOk;
		ctl_next.supplySync = ctl_reg.supplyMeta;
		if (regWrite) begin
			unique case (regAddr)
				`RTCDST_OFF_SCALE: begin
					ctl_next.tempSenseEnable = regWdata[`RTCDST_BIT_TSE];
					ctl_next.backupMode = regWdata[6:5];
					ctl_next.compStart = regWdata[`RTCDST_BIT_TSE];
				end
				`RTCDST_OFF_FWD_MONTH: ctl_next.fwdMonth = regWdata;
				`RTCDST_OFF_FWD_WEEKDAY: ctl_next.fwdWeekDay = regWdata;
				`RTCDST_OFF_FWD_DATE: ctl_next.fwdDate = regWdata;
				`RTCDST_OFF_FWD_HOUR: ctl_next.fwdHour = regWdata;
				`RTCDST_OFF_REV_MONTH: ctl_next.revMonth = regWdata;
				`RTCDST_OFF_REV_WEEKDAY: ctl_next.revWeekDay = regWdata;
				`RTCDST_OFF_REV_DATE: ctl_next.revDate = regWdata;
				`RTCDST_OFF_REV_HOUR: ctl_next.revHour = regWdata;
				default: ;
			endcase
		end
		if (ctl_reg.fwdMonth[`RTCDST_BIT_SAVE_EN]) begin
			if (fwdHit && !ctl_reg.applied) begin
				ctl_next.fwdPulse = 1'b1;
				ctl_next.applied = 1'b1;
			end else if (revHit && ctl_reg.applied) begin
				ctl_next.revPulse = 1'b1;
				ctl_next.applied = 1'b0;
			end
		end
		if (!ctl_next.fwdMonth[`RTCDST_BIT_SAVE_EN]) begin
			ctl_next.applied = 1'b0;
			ctl_next.fwdPulse = 1'b0;
			ctl_next.revPulse = 1'b0;
		end
		if (regRead) begin
			unique case (regAddr)
				`RTCDST_OFF_INTERCEPT: ctl_next.rdata = ctl_reg.intercept;
				`RTCDST_OFF_CURVE: ctl_next.rdata = ctl_reg.curve;
				`RTCDST_OFF_SCALE: ctl_next.rdata = {ctl_reg.tempSenseEnable,
					ctl_reg.backupMode, ctl_reg.scaleTrim};
				`RTCDST_OFF_FWD_MONTH: ctl_next.rdata = ctl_reg.fwdMonth;
				`RTCDST_OFF_FWD_WEEKDAY: ctl_next.rdata = ctl_reg.fwdWeekDay;
				`RTCDST_OFF_FWD_DATE: ctl_next.rdata = ctl_reg.fwdDate;
				`RTCDST_OFF_FWD_HOUR: ctl_next.rdata = ctl_reg.fwdHour;
				`RTCDST_OFF_REV_MONTH: ctl_next.rdata = ctl_reg.revMonth;
				`RTCDST_OFF_REV_WEEKDAY: ctl_next.rdata = ctl_reg.revWeekDay;
				`RTCDST_OFF_REV_DATE: ctl_next.rdata = ctl_reg.revDate;
				`RTCDST_OFF_REV_HOUR: ctl_next.rdata = ctl_reg.revHour;
				default: ctl_next.rdata = `RTCDST_RDATA_UNMAPPED;
			endcase
		end
	end

	// Power-up loads the factory trims; intercept, curve and scale trim have no write path.
	always_ff @(posedge clk) begin
		if (reset) begin
			ctl_reg <= '{tempSenseEnable: 1'b0, backupMode: 2'h0,
				scaleTrim: factoryScale,
				intercept: factoryIntercept, curve: factoryCurve,
				fwdMonth: `RTCDST_DST_RESET, fwdWeekDay: `RTCDST_DST_RESET,
				fwdDate: `RTCDST_DST_RESET, fwdHour: `RTCDST_DST_RESET,
				revMonth: `RTCDST_DST_RESET, revWeekDay: `RTCDST_DST_RESET,
				revDate: `RTCDST_DST_RESET, revHour: `RTCDST_DST_RESET,
				applied: 1'b0, fwdPulse: 1'b0, revPulse: 1'b0, compStart: 1'b0,
				supplyMeta: 1'b1, supplySync: 1'b1,
				rdata: `RTCDST_RDATA_UNMAPPED};
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	rtcdst_comp_seq #(
		.TRIM_RESET(TRIM_RESET)
	) compSeq (
		.clk(clk),
		.reset(reset),
		.secondTick(secondTick),
		.tempSenseEnable(ctl_reg.tempSenseEnable),
		.backupMode(ctl_reg.backupMode),
		.mainSupplyOk(ctl_reg.supplySync),
		.startReq(ctl_reg.compStart),
		.convDone(convDone),
		.convTemp(convTemp),
		.convAnalog(convAnalog),
		.convDigital(convDigital),
		.convStart(convStart),
		.analogTrim(analogFreqTrim),
		.digitalTrim(digitalFreqTrim)
	);

	assign regRdata = ctl_reg.rdata;
	assign saveForwardPulse = ctl_reg.fwdPulse;
	assign saveReversePulse = ctl_reg.revPulse;
	assign savingForwardApplied = ctl_reg.applied;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	scale_trim_kept_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_SCALE |=> $stable(ctl_reg.scaleTrim))
		else $error("Scale write changed the trimmed scale value.");
	scale_ctrl_taken_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_SCALE |=>
		{ctl_reg.tempSenseEnable, ctl_reg.backupMode} == $past(regWdata[7:5]))
		else $error("Scale control bits did not take the written value.");
	ro_regs_kept_a: assert property (
		regWrite && (regAddr == `RTCDST_OFF_INTERCEPT || regAddr == `RTCDST_OFF_CURVE)
		|=> $stable(ctl_reg.intercept) && $stable(ctl_reg.curve))
		else $error("Read-only trim register changed on a write.");
	month_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_FWD_MONTH |=> regRdata == $past(ctl_reg.fwdMonth))
		else $error("Forward month read returned the wrong value.");
	fwd_sets_flag_a: assert property (
		saveForwardPulse |-> savingForwardApplied && !$past(savingForwardApplied))
		else $error("Forward adjustment did not set the applied flag.");
	rev_clears_flag_a: assert property (
		saveReversePulse |-> !savingForwardApplied && $past(savingForwardApplied))
		else $error("Reverse adjustment did not clear the applied flag.");
	enable_clear_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_FWD_MONTH && !regWdata[7] |=>
		!savingForwardApplied ##1 !saveForwardPulse)
		else $error("Clearing saving enable left the applied flag set.");
	fwd_on_hit_a: assert property (
		saveForwardPulse |-> $past(fwdHit) && $past(ctl_reg.fwdMonth[7]))
		else $error("Forward adjustment without a matching enabled point.");
	comp_kick_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_SCALE && regWdata[7] |=> ##1 convStart)
		else $error("Scale write with sensing enabled did not request conversion.");
	scale_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_SCALE
		|=> regRdata[4:0] == $past(ctl_reg.scaleTrim))
		else $error("Scale read lost the trimmed value.");
	scale_ctrl_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_SCALE |=> regRdata[7] == $past(ctl_reg.tempSenseEnable)
		&& regRdata[6:5] == $past(ctl_reg.backupMode))
		else $error("Scale read returned wrong control bits.");
	intercept_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_INTERCEPT
		|=> regRdata == $past(ctl_reg.intercept))
		else $error("Intercept read returned the wrong value.");
	curve_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_CURVE
		|=> regRdata == $past(ctl_reg.curve))
		else $error("Curve read returned the wrong value.");
	fwd_month_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_FWD_MONTH
		|=> ctl_reg.fwdMonth == $past(regWdata))
		else $error("Forward month write was lost.");
	fwd_week_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_FWD_WEEKDAY
		|=> ctl_reg.fwdWeekDay == $past(regWdata))
		else $error("Forward week write was lost.");
	fwd_date_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_FWD_DATE
		|=> ctl_reg.fwdDate == $past(regWdata))
		else $error("Forward date write was lost.");
	fwd_hour_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_FWD_HOUR
		|=> ctl_reg.fwdHour == $past(regWdata))
		else $error("Forward hour write was lost.");
	rev_month_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_REV_MONTH
		|=> ctl_reg.revMonth == $past(regWdata))
		else $error("Reverse month write was lost.");
	rev_week_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_REV_WEEKDAY
		|=> ctl_reg.revWeekDay == $past(regWdata))
		else $error("Reverse week write was lost.");
	rev_date_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_REV_DATE
		|=> ctl_reg.revDate == $past(regWdata))
		else $error("Reverse date write was lost.");
	rev_hour_wr_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_REV_HOUR
		|=> ctl_reg.revHour == $past(regWdata))
		else $error("Reverse hour write was lost.");
	fwd_week_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_FWD_WEEKDAY
		|=> regRdata == $past(ctl_reg.fwdWeekDay))
		else $error("Forward week read returned the wrong value.");
	rev_week_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_REV_WEEKDAY
		|=> regRdata == $past(ctl_reg.revWeekDay))
		else $error("Reverse week read returned the wrong value.");
	fwd_hour_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_FWD_HOUR
		|=> regRdata == $past(ctl_reg.fwdHour))
		else $error("Forward hour read returned the wrong value.");
	rev_hour_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_REV_HOUR
		|=> regRdata == $past(ctl_reg.revHour))
		else $error("Reverse hour read returned the wrong value.");
	rev_month_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_REV_MONTH
		|=> regRdata == $past(ctl_reg.revMonth))
		else $error("Reverse month read returned the wrong value.");
	fwd_date_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_FWD_DATE
		|=> regRdata == $past(ctl_reg.fwdDate))
		else $error("Forward date read returned the wrong value.");
	rev_date_read_a: assert property (
		regRead && regAddr == `RTCDST_OFF_REV_DATE
		|=> regRdata == $past(ctl_reg.revDate))
		else $error("Reverse date read returned the wrong value.");
	rev_on_hit_a: assert property (
		saveReversePulse
		|-> $past(revHit) && $past(ctl_reg.fwdMonth[`RTCDST_BIT_SAVE_EN]))
		else $error("Reverse adjustment without a matching enabled point.");
	one_pulse_a: assert property (
		saveForwardPulse
		|-> !saveReversePulse)
		else $error("Forward and reverse adjustment at once.");
	fwd_short_a: assert property (
		saveForwardPulse
		|=> !saveForwardPulse)
		else $error("Forward adjustment repeated.");
	rev_short_a: assert property (
		saveReversePulse
		|=> !saveReversePulse)
		else $error("Reverse adjustment repeated.");
	disabled_quiet_a: assert property (
		!ctl_reg.fwdMonth[`RTCDST_BIT_SAVE_EN]
		|=> !saveForwardPulse && !saveReversePulse)
		else $error("Adjustment while saving time is disabled.");
	flag_steady_a: assert property (
		ctl_reg.fwdMonth[`RTCDST_BIT_SAVE_EN] && !saveForwardPulse && !saveReversePulse
		|-> $stable(savingForwardApplied))
		else $error("Applied flag changed without an adjustment.");
	disabled_flag_a: assert property (
		!ctl_reg.fwdMonth[`RTCDST_BIT_SAVE_EN]
		|-> !savingForwardApplied)
		else $error("Applied flag set while saving time is disabled.");
	sense_off_write_a: assert property (
		regWrite && regAddr == `RTCDST_OFF_SCALE && !regWdata[`RTCDST_BIT_TSE]
		|=> !ctl_reg.compStart)
		else $error("Scale write with sensing off started a cycle.");
	trims_quiet_a: assert property (
		!convDone
		|=> $stable(analogFreqTrim) && $stable(digitalFreqTrim))
		else $error("Trims changed without a finished conversion.");
	backup_off_a: assert property (
		!ctl_reg.supplySync && ctl_reg.backupMode == 2'h0 && !ctl_reg.compStart
		|=> !convStart)
		else $error("Conversion started on backup with compensation off.");
	sense_off_a: assert property (
		!ctl_reg.tempSenseEnable && !ctl_reg.compStart
		|=> !convStart)
		else $error("Conversion started with sensing disabled.");
	cover_forward_c: cover property (saveForwardPulse);
	cover_reverse_c: cover property (saveReversePulse);
	cover_last_week_c: cover property (revHit && ctl_reg.revWeekDay[5:3] == 3'h7);
	cover_backup_c: cover property (!ctl_reg.supplySync && convStart);
endmodule

// >>> verilog/rtcdst_pkg.sv
// Types shared by the compensation sequencer and the control block.
// Assumes the constants header is on the include path.
package rtcdst_pkg;
	typedef enum logic [0:0] {COMP_IDLE, COMP_WAIT} rtcdst_comp_state_t;

	typedef struct packed {
		rtcdst_comp_state_t state;
		logic [10:0] secCount;
		logic [9:0] lastTemp;
		logic tempValid;
		logic convStart;
		logic [7:0] analogTrim;
		logic [7:0] digitalTrim;
	} rtcdst_comp_t;

	typedef struct packed {
		logic tempSenseEnable;
		logic [1:0] backupMode;
		logic [4:0] scaleTrim;
		logic [7:0] intercept;
		logic [7:0] curve;
		logic [7:0] fwdMonth;
		logic [7:0] fwdWeekDay;
		logic [7:0] fwdDate;
		logic [7:0] fwdHour;
		logic [7:0] revMonth;
		logic [7:0] revWeekDay;
		logic [7:0] revDate;
		logic [7:0] revHour;
		logic applied;
		logic fwdPulse;
		logic revPulse;
		logic compStart;
		logic supplyMeta;
		logic supplySync;
		logic [7:0] rdata;
	} rtcdst_ctl_t;
endpackage

// >>> verilog/rtcdst_regs.svh
// Register offsets, field positions and timing constants of the compensation and saving-time block.
// Assumes it is included by bare name from the design modules.
`ifndef RTCDST_REGS_SVH
`define RTCDST_REGS_SVH
`define RTCDST_OFF_INTERCEPT 8'h0b
`define RTCDST_OFF_CURVE 8'h0c
`define RTCDST_OFF_SCALE 8'h0d
`define RTCDST_OFF_FWD_MONTH 8'h15
`define RTCDST_OFF_FWD_WEEKDAY 8'h16
`define RTCDST_OFF_FWD_DATE 8'h17
`define RTCDST_OFF_FWD_HOUR 8'h18
`define RTCDST_OFF_REV_MONTH 8'h19
`define RTCDST_OFF_REV_WEEKDAY 8'h1a
`define RTCDST_OFF_REV_DATE 8'h1b
`define RTCDST_OFF_REV_HOUR 8'h1c
`define RTCDST_BIT_TSE 7
`define RTCDST_BIT_SAVE_EN 7
`define RTCDST_BIT_WEEK_SEL 6
`define RTCDST_WEEK_LAST 3'h7
`define RTCDST_HOUR_MASK 8'h3f
`define RTCDST_MONTH_MASK 8'h1f
`define RTCDST_DATE_MASK 8'h3f
`define RTCDST_DST_RESET 8'h00
`define RTCDST_RDATA_UNMAPPED 8'h00
`define RTCDST_PERIOD_MAIN_S 11'h03c
`define RTCDST_PERIOD_BK1_S 11'h03c
`define RTCDST_PERIOD_BK2_S 11'h258
`define RTCDST_PERIOD_BK3_S 11'h708
`endif
